//--- adsba_pkg.sv
/*
 * Shared constants and types for the conversion sequencer with busy and
 * alert indicators: timing, channel codes, mode encodings, lane masks and
 * reset values.
 * Assumes a single 25 MHz system clock.
 */
package adsba_pkg;

   // system clock and conversion phase length
   localparam int CLK_PERIOD_NS = 40;
   localparam int CONV_TIME_NS = 400;
   // a least time, so round up to whole cycles
   localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] CONV_CNT_LAST = 4'(CONV_CYCLES - 1);
   localparam logic [3:0] CONV_CNT_RESET = 4'h0;

   // channel codes: 0..15 are analog inputs, 16 is the temperature sensor
   localparam int NUM_INPUTS = 16;
   localparam logic [4:0] TEMP_CHANNEL = 5'h10;
   localparam logic [4:0] MUX_RESET = 5'h00;
   localparam logic [6:0] SLOTS_NONE = 7'h00;

   // sequencing modes
   typedef enum logic [1:0] {
      ADSBA_STD = 2'b00,
      ADSBA_ADV = 2'b01,
      ADSBA_CMD2 = 2'b10,
      ADSBA_CMD1 = 2'b11
   } adsba_mode_t;
   localparam adsba_mode_t MODE_RESET = ADSBA_STD;

   // output lane modes and the lanes each one uses
   localparam logic [1:0] LANE_SINGLE = 2'h0;
   localparam logic [1:0] LANE_DUAL = 2'h1;
   localparam logic [1:0] LANE_QUAD = 2'h2;
   localparam logic [3:0] MASK_SINGLE = 4'h1;
   localparam logic [3:0] MASK_DUAL = 4'h3;
   localparam logic [3:0] MASK_QUAD = 4'hF;

   // oversampling field codes and the last count of each ratio
   localparam logic [1:0] OSR_1 = 2'h0;
   localparam logic [1:0] OSR_4 = 2'h1;
   localparam logic [1:0] OSR_16 = 2'h2;
   localparam logic [5:0] OSR_LAST_1 = 6'h00;
   localparam logic [5:0] OSR_LAST_4 = 6'h03;
   localparam logic [5:0] OSR_LAST_16 = 6'h0F;
   localparam logic [5:0] OSR_LAST_64 = 6'h3F;
   localparam logic [5:0] OSR_CNT_RESET = 6'h00;

endpackage : adsba_pkg

//--- adsba_conv_timer.sv
/*
 * Conversion phase timer: one start pulse opens a conversion phase of a
 * fixed number of clock cycles and a done pulse marks its last cycle.
 * Assumes the caller only starts it while it is idle.
 */
`timescale 1ns/100ps
module adsba_conv_timer (
   input wire logic clk,
   input wire logic resetn,
   input wire logic start,
   output logic active,
   output logic done
);

   logic [3:0] cnt_reg;
   logic active_reg;

   // count the conversion phase; a start while active is ignored
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt_reg <= adsba_pkg::CONV_CNT_RESET;
         active_reg <= 1'b0;
      end else if (start && !active_reg) begin
         cnt_reg <= adsba_pkg::CONV_CNT_RESET;
         active_reg <= 1'b1;
      end else if (active_reg) begin
         if (cnt_reg == adsba_pkg::CONV_CNT_LAST) begin
            active_reg <= 1'b0;
         end else begin
            cnt_reg <= cnt_reg + 4'h1;
         end
      end
   end

   // done is high in the last cycle of the phase only
   assign active = active_reg;
   assign done = active_reg && (cnt_reg == adsba_pkg::CONV_CNT_LAST);

endmodule : adsba_conv_timer

//--- adsba_seq_busy_alert.sv
/*
 * Conversion-mode control: channel sequencing mode decode, the standard
 * sequencer with oversampling-aware advance, command-mode channel follow,
 * busy indication on serial outputs and general pins, alert on pins.
 * Assumes all inputs are synchronous to CLK; threshold flags, command
 * decoding and advanced slot logic sit outside and drive their ports.
 */
`timescale 1ns/100ps

module adsba_seq_busy_alert (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic CONVERSION_START_PIN,
   input wire logic CONVERSION_MODE,
   input wire logic PACKAGE_BALL_GRID,
   input wire logic ALERT_PIN_ENABLE,
   input wire logic ALERT_PIN_SELECT,
   input wire logic BUSY_PIN_ENABLE,
   input wire logic BUSY_PIN_SELECT,
   input wire logic SERIAL_OUT_BUSY_ENABLE,
   input wire logic [1:0] OUTPUT_LANE_MODE,
   input wire logic CHIP_SELECT_N,
   input wire logic STANDARD_SEQUENCER_ENABLE,
   input wire logic [6:0] ADVANCED_SLOT_COUNT,
   input wire logic CYCLE_CONTROL,
   input wire logic [15:0] STANDARD_CHANNEL_ENABLES,
   input wire logic TEMP_SENSOR_ENABLE,
   input wire logic INPUT_PAIRING,
   input wire logic [1:0] OVERSAMPLE_RATIO_FIELD,
   input wire logic [4:0] SLOT_ZERO_CHANNEL,
   input wire logic [4:0] ADVANCED_NEXT_CHANNEL,
   input wire logic COMMAND_STROBE,
   input wire logic COMMAND_VALID,
   input wire logic [4:0] COMMAND_CHANNEL,
   input wire logic [15:0] UPPER_ALERT_FLAG,
   input wire logic [15:0] LOWER_ALERT_FLAG,
   output logic [4:0] MUX_CHANNEL,
   output logic [1:0] SEQUENCE_MODE,
   output logic CONVERTING,
   output logic RESULT_READY,
   output logic THRESHOLD_ALERT_ANY,
   output logic MULTI_FUNCTION_PIN_ZERO_OUT,
   output logic MULTI_FUNCTION_PIN_ZERO_OE_N,
   output logic GENERAL_PIN_TWO_OUT,
   output logic GENERAL_PIN_TWO_OE_N,
   output logic GENERAL_PIN_THREE_OUT,
   output logic GENERAL_PIN_THREE_OE_N,
   output logic [3:0] SERIAL_DATA_OUT,
   output logic [3:0] SERIAL_DATA_OE_N
);

   // decode the sequencing mode; illegal mixes fall back to standard
   function automatic adsba_pkg::adsba_mode_t adsba_decode_mode(
      input logic std_en, input logic [6:0] slots, input logic cyc);
      adsba_pkg::adsba_mode_t m;
      m = adsba_pkg::ADSBA_STD;
      if (!std_en && slots == adsba_pkg::SLOTS_NONE && !cyc) begin
         m = adsba_pkg::ADSBA_CMD2;
      end else if (!std_en && slots == adsba_pkg::SLOTS_NONE && cyc) begin
         m = adsba_pkg::ADSBA_CMD1;
      end else if (!std_en && !cyc) begin
         m = adsba_pkg::ADSBA_ADV;
      end
      return m;
   endfunction : adsba_decode_mode

   // next enabled channel above cur, wrapping through the sensor slot
   function automatic logic [4:0] adsba_next_chan(
      input logic [4:0] cur, input logic [16:0] en);
      logic [4:0] pos;
      logic [4:0] found;
      logic hit;
      pos = cur;
      found = adsba_pkg::MUX_RESET;
      hit = 1'b0;
      for (int i = 0; i < adsba_pkg::NUM_INPUTS + 1; i++) begin
         pos = (pos == adsba_pkg::TEMP_CHANNEL) ? 5'h00 : pos + 5'h01;
         if (!hit && en[pos]) begin
            found = pos;
            hit = 1'b1;
         end
      end
      return found;
   endfunction : adsba_next_chan

   // an odd input of a pair selects its even partner
   function automatic logic [4:0] adsba_pair_adj(input logic [4:0] ch, input logic pair);
      return {ch[4:1], ch[0] & ~pair};
   endfunction : adsba_pair_adj

   // last conversion count for the oversampling field
   function automatic logic [5:0] adsba_osr_last(input logic [1:0] field);
      logic [5:0] last;
      case (field)
         adsba_pkg::OSR_1: last = adsba_pkg::OSR_LAST_1;
         adsba_pkg::OSR_4: last = adsba_pkg::OSR_LAST_4;
         adsba_pkg::OSR_16: last = adsba_pkg::OSR_LAST_16;
         default: last = adsba_pkg::OSR_LAST_64;
      endcase
      return last;
   endfunction : adsba_osr_last

   adsba_pkg::adsba_mode_t mode_reg;
   adsba_pkg::adsba_mode_t mode_next;
   logic [4:0] mux_reg;
   logic [4:0] first_chan;
   logic [4:0] std_next_chan;
   logic [16:0] en_eff;
   logic cnv_prev_reg;
   logic cnv_rise;
   logic conv_start;
   logic conv_active;
   logic conv_done;
   logic [5:0] osr_cnt_reg;
   logic result_now;
   logic busy_reg;
   logic ready_reg;
   logic ready_seen_reg;
   logic cmd_pend_reg;
   logic [4:0] cmd_chan_reg;
   logic cmd_take;
   logic alert_next;
   logic alert_reg;
   logic [3:0] lane_mask;
   logic [3:0] sdo_oe_n_next;
   logic [3:0] sdo_oe_n_reg;
   logic [3:0] sdo_out_reg;
   logic gp0_busy;
   logic gp0_alert;
   logic gp2_alert;
   logic gp3_busy;
   logic gp0_out_reg;
   logic gp0_oe_n_reg;
   logic gp2_out_reg;
   logic gp2_oe_n_reg;
   logic gp3_out_reg;
   logic gp3_oe_n_reg;

   assign mode_next = adsba_decode_mode(STANDARD_SEQUENCER_ENABLE, ADVANCED_SLOT_COUNT,
                                        CYCLE_CONTROL);

   // per-input enables, pairing from input zero folds odd into even
   generate
      for (genvar k = 0; k < adsba_pkg::NUM_INPUTS / 2; k++) begin : g_pair
         assign en_eff[2*k] = STANDARD_CHANNEL_ENABLES[2*k] |
                              (INPUT_PAIRING & STANDARD_CHANNEL_ENABLES[2*k+1]);
         assign en_eff[2*k+1] = STANDARD_CHANNEL_ENABLES[2*k+1] & ~INPUT_PAIRING;
      end
   endgenerate
   assign en_eff[16] = TEMP_SENSOR_ENABLE;

   assign first_chan = adsba_next_chan(adsba_pkg::TEMP_CHANNEL, en_eff);
   assign std_next_chan = adsba_next_chan(mux_reg, en_eff);

   // mode is frozen while converting so a mid-run write cannot tear it
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         mode_reg <= adsba_pkg::MODE_RESET;
      end else if (!CONVERSION_MODE) begin
         mode_reg <= mode_next;
      end
   end

   // start edge detect; a rise during a running phase is ignored
   assign cnv_rise = CONVERSION_START_PIN && !cnv_prev_reg;
   assign conv_start = cnv_rise && CONVERSION_MODE && !conv_active;

   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         cnv_prev_reg <= 1'b0;
      end else begin
         cnv_prev_reg <= CONVERSION_START_PIN;
      end
   end

   adsba_conv_timer u_conv_timer (
      .clk(CLK),
      .resetn(RESETN),
      .start(conv_start),
      .active(conv_active),
      .done(conv_done)
   );

   // result only after the whole oversampling run
   assign result_now = conv_done &&
                       (osr_cnt_reg == adsba_osr_last(OVERSAMPLE_RATIO_FIELD));

   always_ff @(posedge CLK) begin
      if (!RESETN || !CONVERSION_MODE) begin
         osr_cnt_reg <= adsba_pkg::OSR_CNT_RESET;
      end else if (result_now) begin
         osr_cnt_reg <= adsba_pkg::OSR_CNT_RESET;
      end else if (conv_done) begin
         osr_cnt_reg <= osr_cnt_reg + 6'h01;
      end
   end

   // busy from start edge until the result is ready
   always_ff @(posedge CLK) begin
      if (!RESETN || !CONVERSION_MODE) begin
         busy_reg <= 1'b0;
         ready_reg <= 1'b0;
         ready_seen_reg <= 1'b0;
      end else begin
         ready_reg <= result_now;
         if (result_now) begin
            busy_reg <= 1'b0;
            ready_seen_reg <= 1'b1;
         end else if (conv_start) begin
            busy_reg <= 1'b1;
            ready_seen_reg <= 1'b0;
         end
      end
   end

   // host commands, taken only in the command modes
   assign cmd_take = COMMAND_STROBE && COMMAND_VALID && CONVERSION_MODE &&
                     (mode_reg == adsba_pkg::ADSBA_CMD2 || mode_reg == adsba_pkg::ADSBA_CMD1);

   // two-cycle mode parks the command until the next acquisition start
   always_ff @(posedge CLK) begin
      if (!RESETN || !CONVERSION_MODE) begin
         cmd_pend_reg <= 1'b0;
         cmd_chan_reg <= adsba_pkg::MUX_RESET;
      end else if (cmd_take) begin
         cmd_pend_reg <= 1'b1;
         cmd_chan_reg <= COMMAND_CHANNEL;
      end else if (result_now) begin
         cmd_pend_reg <= 1'b0;
      end
   end

   // channel moves at acquisition start; a single-cycle command moves it at once
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         mux_reg <= adsba_pkg::MUX_RESET;
      end else if (!CONVERSION_MODE) begin
         if (mode_next == adsba_pkg::ADSBA_STD) begin
            mux_reg <= first_chan;
         end else begin
            mux_reg <= adsba_pair_adj(SLOT_ZERO_CHANNEL, INPUT_PAIRING);
         end
      end else if (cmd_take && mode_reg == adsba_pkg::ADSBA_CMD1) begin
         mux_reg <= adsba_pair_adj(COMMAND_CHANNEL, INPUT_PAIRING);
      end else if (result_now) begin
         case (mode_reg)
            adsba_pkg::ADSBA_STD: mux_reg <= std_next_chan;
            adsba_pkg::ADSBA_ADV: mux_reg <= adsba_pair_adj(ADVANCED_NEXT_CHANNEL,
                                                           INPUT_PAIRING);
            adsba_pkg::ADSBA_CMD2: begin
               if (cmd_pend_reg) begin
                  mux_reg <= adsba_pair_adj(cmd_chan_reg, INPUT_PAIRING);
               end
            end
            default: mux_reg <= mux_reg;
         endcase
      end
   end

   assign alert_next = |(UPPER_ALERT_FLAG | LOWER_ALERT_FLAG);

   // pin zero on lead-frame, or on ball-grid with select low; select ignored on lead-frame
   assign gp0_alert = ALERT_PIN_ENABLE && (!PACKAGE_BALL_GRID || !ALERT_PIN_SELECT);
   // ball-grid select moves alert to pin two
   assign gp2_alert = ALERT_PIN_ENABLE && PACKAGE_BALL_GRID && ALERT_PIN_SELECT;
   assign gp0_busy = BUSY_PIN_ENABLE && (!PACKAGE_BALL_GRID || !BUSY_PIN_SELECT);
   // ball-grid select moves busy to pin three
   assign gp3_busy = BUSY_PIN_ENABLE && PACKAGE_BALL_GRID && BUSY_PIN_SELECT;

   // pins driven every cycle; chip select is deliberately not looked at
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         alert_reg <= 1'b0;
         gp0_out_reg <= 1'b0;
         gp0_oe_n_reg <= 1'b1;
         gp2_out_reg <= 1'b0;
         gp2_oe_n_reg <= 1'b1;
         gp3_out_reg <= 1'b0;
         gp3_oe_n_reg <= 1'b1;
      end else begin
         alert_reg <= alert_next;
         // busy pin wins pin zero if both claim it
         if (gp0_busy) begin
            gp0_out_reg <= busy_reg;
            gp0_oe_n_reg <= 1'b0;
         end else begin
            gp0_out_reg <= gp0_alert & alert_next;
            gp0_oe_n_reg <= !gp0_alert;
         end
         gp2_out_reg <= gp2_alert & alert_next;
         gp2_oe_n_reg <= !gp2_alert;
         gp3_out_reg <= gp3_busy & busy_reg;
         gp3_oe_n_reg <= !gp3_busy;
      end
   end

   // lanes used by each lane mode
   always_comb begin
      case (OUTPUT_LANE_MODE)
         adsba_pkg::LANE_SINGLE: lane_mask = adsba_pkg::MASK_SINGLE;
         adsba_pkg::LANE_DUAL: lane_mask = adsba_pkg::MASK_DUAL;
         adsba_pkg::LANE_QUAD: lane_mask = adsba_pkg::MASK_QUAD;
         default: lane_mask = adsba_pkg::MASK_SINGLE;
      endcase
   end

   // lanes released while converting, pulled low once ready
   generate
      for (genvar g = 0; g < 4; g++) begin : g_lane
         assign sdo_oe_n_next[g] = !(SERIAL_OUT_BUSY_ENABLE && lane_mask[g] &&
                                     !CHIP_SELECT_N && ready_seen_reg && !busy_reg);
      end
   endgenerate

   // lanes only ever drive low; the external pull-ups give the high
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         sdo_oe_n_reg <= 4'hF;
         sdo_out_reg <= 4'h0;
      end else begin
         sdo_oe_n_reg <= sdo_oe_n_next;
         sdo_out_reg <= 4'h0;
      end
   end

   assign MUX_CHANNEL = mux_reg;
   assign SEQUENCE_MODE = mode_reg;
   assign CONVERTING = busy_reg;
   assign RESULT_READY = ready_reg;
   assign THRESHOLD_ALERT_ANY = alert_reg;
   assign MULTI_FUNCTION_PIN_ZERO_OUT = gp0_out_reg;
   assign MULTI_FUNCTION_PIN_ZERO_OE_N = gp0_oe_n_reg;
   assign GENERAL_PIN_TWO_OUT = gp2_out_reg;
   assign GENERAL_PIN_TWO_OE_N = gp2_oe_n_reg;
   assign GENERAL_PIN_THREE_OUT = gp3_out_reg;
   assign GENERAL_PIN_THREE_OE_N = gp3_oe_n_reg;
   assign SERIAL_DATA_OUT = sdo_out_reg;
   assign SERIAL_DATA_OE_N = sdo_oe_n_reg;

   AST_ALERT_GP0: assert property (
      @(posedge CLK) disable iff (!RESETN)
      (gp0_alert && !gp0_busy) |=> (!MULTI_FUNCTION_PIN_ZERO_OE_N &&
         MULTI_FUNCTION_PIN_ZERO_OUT == $past(alert_next)))
      else $error("alert level missing on pin zero");

   AST_ALERT_GP2: assert property (
      @(posedge CLK) disable iff (!RESETN)
      gp2_alert |=> (!GENERAL_PIN_TWO_OE_N && GENERAL_PIN_TWO_OUT == THRESHOLD_ALERT_ANY))
      else $error("alert level missing on pin two");

   // lead-frame never uses pins two and three
   AST_LEAD_FRAME: assert property (
      @(posedge CLK) disable iff (!RESETN)
      !PACKAGE_BALL_GRID |=> (GENERAL_PIN_TWO_OE_N && GENERAL_PIN_THREE_OE_N))
      else $error("pin two or three driven on lead-frame");

   AST_SDO_HIZ_BUSY: assert property (
      @(posedge CLK) disable iff (!RESETN)
      CONVERTING |=> (SERIAL_DATA_OE_N == 4'hF))
      else $error("serial lane driven while converting");

   // single lane mode drives primary lane only
   AST_SDO_LANES: assert property (
      @(posedge CLK) disable iff (!RESETN)
      (SERIAL_OUT_BUSY_ENABLE && !CHIP_SELECT_N && ready_seen_reg && !busy_reg &&
       OUTPUT_LANE_MODE == adsba_pkg::LANE_SINGLE) |=> (SERIAL_DATA_OE_N == 4'hE))
      else $error("wrong lanes driven in single lane mode");

   AST_CS_HIZ: assert property (
      @(posedge CLK) disable iff (!RESETN)
      CHIP_SELECT_N |=> (SERIAL_DATA_OE_N == 4'hF))
      else $error("serial lane driven with chip select high");

   // busy on pin three tracks conversion
   AST_BUSY_GP3: assert property (
      @(posedge CLK) disable iff (!RESETN)
      gp3_busy |=> (!GENERAL_PIN_THREE_OE_N && GENERAL_PIN_THREE_OUT == $past(CONVERTING)))
      else $error("busy level missing on pin three");

   // busy pin zero ignores chip select
   AST_BUSY_GP0_CS: assert property (
      @(posedge CLK) disable iff (!RESETN)
      (gp0_busy && CHIP_SELECT_N) |=> (!MULTI_FUNCTION_PIN_ZERO_OE_N &&
         MULTI_FUNCTION_PIN_ZERO_OUT == $past(busy_reg)))
      else $error("busy pin zero released by chip select");

   AST_MODE_CMD1: assert property (
      @(posedge CLK) disable iff (!RESETN)
      (!CONVERSION_MODE && !STANDARD_SEQUENCER_ENABLE && ADVANCED_SLOT_COUNT == 7'h00 &&
       CYCLE_CONTROL) |=> (SEQUENCE_MODE == adsba_pkg::ADSBA_CMD1))
      else $error("single-cycle command mode not decoded");

   AST_STD_ADVANCE: assert property (
      @(posedge CLK) disable iff (!RESETN)
      (CONVERSION_MODE && result_now && mode_reg == adsba_pkg::ADSBA_STD) |=>
         (MUX_CHANNEL == $past(std_next_chan) && RESULT_READY && !CONVERTING))
      else $error("standard sequencer did not advance at result");

   AST_RESET_STD: assert property (
      @(posedge CLK) !RESETN |=> (SEQUENCE_MODE == adsba_pkg::ADSBA_STD))
      else $error("mode not standard after reset");

   // no result before oversampling run ends
   AST_OSR_HOLD: assert property (
      @(posedge CLK) disable iff (!RESETN)
      (CONVERSION_MODE && mode_reg != adsba_pkg::ADSBA_CMD1 && conv_done &&
       osr_cnt_reg != adsba_osr_last(OVERSAMPLE_RATIO_FIELD)) |=>
         (!RESULT_READY && $stable(MUX_CHANNEL)))
      else $error("result or channel move before oversampling done");

   // busy rises after an accepted start edge
   AST_BUSY_RISE: assert property (
      @(posedge CLK) disable iff (!RESETN)
      conv_start |=> CONVERTING ##1 conv_active)
      else $error("busy did not follow start edge");

endmodule : adsba_seq_busy_alert

//--- adsba_host_model.sv
/* host controller model: turns a fire request into a conversion start edge.
   assumes fire is a one-clock pulse at most once every 12 clocks. */
`timescale 1ns/100ps
module adsba_host_model (
   input wire logic clk,
   input wire logic fire,
   output logic start_pin
);
   // start pin follows the request one clock later, so each request is one rising edge
   always_ff @(posedge clk) begin
      start_pin <= fire;
   end
endmodule : adsba_host_model

//--- adsba_seq_busy_alert_bench.sv
/* self-checking bench for the sequencer with busy and alert pins.
   assumes the design registers outputs one clock after their causes. */
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
   $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module adsba_seq_busy_alert_bench;
   logic clk = 1'b0, rstn = 1'b0, fire = 1'b0, start, conv = 1'b0, bga = 1'b0;
   logic a_en = 1'b0, a_sel = 1'b0, b_en = 1'b0, b_sel = 1'b0, sob = 1'b0, csn = 1'b0;
   logic std = 1'b1, cyc = 1'b0, temp = 1'b0, pair = 1'b0;
   logic [1:0] lane = 2'h0, osr = 2'h0, mode;
   logic [6:0] slots = 7'h00;
   logic cstb = 1'b0, cval = 1'b0;
   logic [4:0] cch = 5'h00;
   logic [15:0] en = 16'h0000, up = 16'h0000, lo = 16'h0000;
   logic [4:0] mux;
   logic conv_o, ready, alert, p0, p0n, p2, p2n, p3, p3n;
   logic [3:0] sdo, sdon;
   int fail_count = 0, samples_checked = 0, readies = 0;
   adsba_host_model adsba_host_model_i (.clk(clk), .fire(fire), .start_pin(start));
   adsba_seq_busy_alert adsba_seq_busy_alert_i (.CLK(clk), .RESETN(rstn),
      .CONVERSION_START_PIN(start), .CONVERSION_MODE(conv), .PACKAGE_BALL_GRID(bga),
      .ALERT_PIN_ENABLE(a_en), .ALERT_PIN_SELECT(a_sel), .BUSY_PIN_ENABLE(b_en),
      .BUSY_PIN_SELECT(b_sel), .SERIAL_OUT_BUSY_ENABLE(sob), .OUTPUT_LANE_MODE(lane),
      .CHIP_SELECT_N(csn), .STANDARD_SEQUENCER_ENABLE(std), .ADVANCED_SLOT_COUNT(slots),
      .CYCLE_CONTROL(cyc), .STANDARD_CHANNEL_ENABLES(en), .TEMP_SENSOR_ENABLE(temp),
      .INPUT_PAIRING(pair), .OVERSAMPLE_RATIO_FIELD(osr), .SLOT_ZERO_CHANNEL(5'h04),
      .ADVANCED_NEXT_CHANNEL(5'h06), .COMMAND_STROBE(cstb), .COMMAND_VALID(cval),
      .COMMAND_CHANNEL(cch), .UPPER_ALERT_FLAG(up), .LOWER_ALERT_FLAG(lo),
      .MUX_CHANNEL(mux), .SEQUENCE_MODE(mode), .CONVERTING(conv_o), .RESULT_READY(ready),
      .THRESHOLD_ALERT_ANY(alert), .MULTI_FUNCTION_PIN_ZERO_OUT(p0),
      .MULTI_FUNCTION_PIN_ZERO_OE_N(p0n), .GENERAL_PIN_TWO_OUT(p2),
      .GENERAL_PIN_TWO_OE_N(p2n), .GENERAL_PIN_THREE_OUT(p3),
      .GENERAL_PIN_THREE_OE_N(p3n), .SERIAL_DATA_OUT(sdo), .SERIAL_DATA_OE_N(sdon));
   // 25 MHz clock
   initial begin
      forever #20 clk = ~clk;
   end
   // ready pulses are counted here so a missing or extra result shows up
   always @(posedge clk) begin
      if (ready === 1'b1) readies++;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask : wait_clk
   // one start request; mid-phase the busy indications are checked when asked
   task automatic phase(input bit busy_chk);
      @(posedge clk) fire <= 1'b1;
      @(posedge clk) fire <= 1'b0;
      repeat (5) @(negedge clk);
      if (busy_chk) begin
         `CHK({p0, p0n, sdon, conv_o}, {1'b1, 1'b0, 4'hF, 1'b1})
      end
      wait_clk(12);
      @(negedge clk);
   endtask : phase
   task automatic close_out();
      $display("checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : close_out
   initial begin
      wait_clk(5000);
      fail_count++;
      close_out();
   end
   initial begin
      wait_clk(5);
      @(negedge clk);
      `CHK({mux, mode, p0n, sdon}, {5'h00, 2'h0, 1'b1, 4'hF})
      @(posedge clk) rstn <= 1'b1;
      // sequencing mode table, oversampling zero for command modes
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         std <= (i == 0);
         slots <= (i == 1) ? 7'h01 : ((i == 0) ? 7'h05 : 7'h00);
         cyc <= (i == 3);
         wait_clk(3);
         `CHK(mode, 2'(i))
      end
      // back to the standard sequencer, the table left single-cycle command mode
      @(posedge clk) {std, cyc, en, pair} <= {2'b10, 16'h0008, 1'b1};
      wait_clk(3);
      `CHK(mux, 5'h02)
      @(posedge clk) en <= 16'h1005;
      pair <= 1'b0;
      temp <= 1'b1;
      wait_clk(3);
      `CHK(mux, 5'h00)
      // busy on pin zero with all four lanes, then chip select high releases the lanes
      @(posedge clk) {b_en, sob, lane, conv} <= {1'b1, 1'b1, 2'h2, 1'b1};
      phase(1'b1);
      `CHK(mux, 5'h02)
      wait_clk(1);
      `CHK({p0, p0n, sdon, sdo}, {1'b0, 1'b0, 4'h0, 4'h0})
      @(posedge clk) csn <= 1'b1;
      wait_clk(2);
      `CHK({sdon, p0n}, {4'hF, 1'b0})
      phase(1'b0);
      `CHK(mux, 5'h0C)
      phase(1'b0);
      `CHK(mux, 5'h10)
      phase(1'b0);
      `CHK({mux, 32'(readies)}, {5'h00, 32'd4})
      // oversampling by four: three phases leave the channel in place
      @(posedge clk) {conv, osr, en, temp, b_en, csn} <= {1'b0, 2'h1, 16'h0005, 3'b0};
      lane <= 2'h0;
      wait_clk(2);
      @(posedge clk) conv <= 1'b1;
      repeat (3) phase(1'b0);
      `CHK({mux, 32'(readies)}, {5'h00, 32'd4})
      phase(1'b0);
      `CHK({mux, sdon, 32'(readies)}, {5'h02, 4'hE, 32'd5})
      // alert on pin two of the ball-grid part
      @(posedge clk) {bga, a_en, a_sel, lo} <= {3'b111, 16'h0100};
      wait_clk(2);
      `CHK({alert, p2, p2n, p0n}, {3'b110, 1'b1})
      @(posedge clk) {bga, lo, up} <= {1'b0, 16'h0000, 16'h8000};
      wait_clk(2);
      `CHK({p0, p0n, p2n}, {3'b101})
      @(posedge clk) {a_en, bga, b_en, b_sel} <= 4'b0111;
      phase(1'b0);
      `CHK({p3, p3n, p0n, conv_o}, {4'b1011})
      @(posedge clk) bga <= 1'b0;
      wait_clk(2);
      `CHK({p3n, p0n, p0}, {3'b101})
      // command modes run without oversampling; single-cycle moves at once
      @(posedge clk) {conv, osr, std, cyc} <= {1'b0, 2'h0, 2'b01};
      wait_clk(2);
      `CHK(mux, 5'h04)
      @(posedge clk) conv <= 1'b1;
      @(posedge clk) {cstb, cval, cch} <= {2'b11, 5'h07};
      @(posedge clk) cstb <= 1'b0;
      @(negedge clk);
      `CHK(mux, 5'h07)
      // two-cycle mode parks the command until the next result
      @(posedge clk) {conv, cyc} <= 2'b00;
      @(posedge clk) conv <= 1'b1;
      @(posedge clk) {cstb, cch} <= {1'b1, 5'h09};
      @(posedge clk) cstb <= 1'b0;
      @(negedge clk);
      `CHK(mux, 5'h04)
      phase(1'b0);
      `CHK(mux, 5'h09)
      close_out();
   end
endmodule : adsba_seq_busy_alert_bench
